// >>> hw/idpc_dio.sv
// Sixteen industrial digital I/O channels: threshold inputs with debounce, FET drive with PWM.
// Assumes ADC results are valid when sampled and config ports are synchronous to sys_clk.
// Operation
// (R1) Sixteen channels, each independently configured as input or output.
// (R2) All inputs sampled together at 200 kHz, one 14-bit result per channel.
// (R3) Input state comes from comparing the sample against high and low thresholds.
// (R4) Above high gives one, below low gives zero, between holds state.
// (R5) Optional debounce accepts a new state after a programmable persistence delay.
// (R6) High-side control at one connects pin to the user output supply.
// (R7) Low-side control at one connects pin to the output ground.
// (R8) High-side and low-side controls of a channel are never both asserted.
// (R9) Both controls off is the off state; pin then serves only as input.
// (R10) Per-pin pull network: pull-up, pull-down, or both for mid-supply.
// (R11) Each channel holds its own PWM mode, frequency, duty and push/pull choice.
// (R12) Continuous mode keeps the duty fixed at the configured value.
// (R13) Soft start ramps duty up from 0% to the configured value.
// (R14) Soft stop ramps duty down to 0% when output goes high to low.
// (R15) Ramps step duty once per PWM period by a configured step size.
// (R16) PWM switches high side only, low side only, or both push/pull.
// (R17) Push/pull inserts a break-before-make dead interval on every transition.
// (R18) Duty is settable from fully off to fully on with 16-bit resolution.
// (R19) Dead interval is a configured count of clock cycles, same both directions.
`timescale 1ns/1ps
`default_nettype none

module idpc_dio
  import idpc_pkg::*;
(
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire idpc_cfg_s [NUM_CH-1:0]            ch_cfg,
  input  wire logic [NUM_CH-1:0][ADC_W-1:0]      adc_data,
  output logic                                   adc_convert,
  output logic [NUM_CH-1:0]                      din_state,
  output logic [NUM_CH-1:0]                      high_side_on,
  output logic [NUM_CH-1:0]                      low_side_on,
  output logic [NUM_CH-1:0]                      pull_up_on,
  output logic [NUM_CH-1:0]                      pull_down_on
);

  // ****************************************
  // Arithmetic helpers
  // ****************************************
  function automatic logic [DUTY_W-1:0] sat_up(input logic [DUTY_W-1:0] cur,
                                               input logic [DUTY_W-1:0] step,
                                               input logic [DUTY_W-1:0] lim);
    logic [DUTY_W:0] sum;
    sum = {1'b0, cur} + {1'b0, step};
    if (sum >= {1'b0, lim}) begin
      return lim;
    end
    return sum[DUTY_W-1:0];
  endfunction : sat_up

  function automatic logic [DUTY_W-1:0] sat_down(input logic [DUTY_W-1:0] cur,
                                                 input logic [DUTY_W-1:0] step);
    if (cur <= step) begin
      return DUTY_ZERO;
    end
    return cur - step;
  endfunction : sat_down

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic thr_decide(input logic [ADC_W-1:0] smp,
                                      input logic [ADC_W-1:0] hi,
                                      input logic [ADC_W-1:0] lo,
                                      input logic             prev);
    if (smp > hi) begin
      return 1'b1;   // (R4)
    end
    if (smp < lo) begin
      return 1'b0;   // (R4)
    end
    return prev;   // (R4)
  endfunction : thr_decide

  function automatic logic pwm_level(input logic [DUTY_W-1:0] phase,
                                     input logic [DUTY_W-1:0] duty);
    if (duty == DUTY_FULL) begin
      return 1'b1;   // (R18)
    end
    return phase < duty;   // (R18)
  endfunction : pwm_level

  function automatic logic [DUTY_W-1:0] ramp_duty(input idpc_pwm_mode_e    mode,
                                                  input logic              level,
                                                  input logic              wrap,
                                                  input logic [DUTY_W-1:0] cur,
                                                  input logic [DUTY_W-1:0] target,
                                                  input logic [DUTY_W-1:0] step);
    case (mode)
      IDPC_PWM_SOFT_START: begin
        if (!level) begin
          return DUTY_ZERO;   // (R13)
        end
        if (cur > target) begin
          return target;
        end
        if (wrap) begin
          return sat_up(cur, step, target);   // (R13) (R15)
        end
        return cur;
      end
      IDPC_PWM_SOFT_STOP: begin
        if (level) begin
          return target;
        end
        if (wrap) begin
          return sat_down(cur, step);   // (R14) (R15)
        end
        return cur;
      end
      default: begin
        return target;   // (R12)
      end
    endcase
  endfunction : ramp_duty

  function automatic logic drive_level(input logic           pwm_en,
                                       input idpc_pwm_mode_e mode,
                                       input logic           level,
                                       input logic           pwm_bit);
    if (!pwm_en) begin
      return level;
    end
    if (mode == IDPC_PWM_SOFT_STOP) begin
      return pwm_bit;   // (R14)
    end
    return level && pwm_bit;
  endfunction : drive_level

  // ****************************************
  // State
  // ****************************************
  idpc_state_s s_q;
  idpc_state_s s_d;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic                tick;
    logic                wrap;
    logic                pwm_bit;
    logic                drive;
    logic                want_h;
    logic                want_l;
    logic [DUTY_W:0]     ph_sum;
    logic [DB_W:0]       db_next;
    logic [ADC_W-1:0]    smp;
    idpc_cfg_s           c;
    s_d     = s_q;
    tick    = 1'b0;
    wrap    = 1'b0;
    pwm_bit = 1'b0;
    drive   = 1'b0;
    want_h  = 1'b0;
    want_l  = 1'b0;
    ph_sum  = '0;
    db_next = '0;
    smp     = '0;
    c       = '0;

    // ****************************************
    // Sample-rate divider
    // ****************************************
    s_d.conv_q = 1'b0;
    if (s_q.div_q == DIV_LAST) begin
      s_d.div_q  = DIV_RST;
      s_d.conv_q = 1'b1;   // (R2)
      tick       = 1'b1;
    end else begin
      s_d.div_q = s_q.div_q + 7'h01;
    end

    for (int i = 0; i < NUM_CH; i++) begin   // (R1)
      c   = ch_cfg[i];
      smp = adc_data[i];

      // ****************************************
      // Input path
      // ****************************************
      if (tick) begin   // (R2)
        s_d.ch[i].raw_q = thr_decide(smp, c.thr_high, c.thr_low, s_q.ch[i].raw_q);   // (R3) (R4)
      end

      // ****************************************
      // Debounce
      // ****************************************
      if (!c.db_en) begin
        s_d.ch[i].lvl_q    = s_q.ch[i].raw_q;
        s_d.ch[i].db_cnt_q = DB_RST;
      end else if (tick) begin
        if (s_q.ch[i].raw_q == s_q.ch[i].lvl_q) begin
          s_d.ch[i].db_cnt_q = DB_RST;
        end else begin
          db_next = {1'b0, s_q.ch[i].db_cnt_q} + 17'h00001;
          if (db_next >= {1'b0, c.db_delay}) begin   // (R5)
            s_d.ch[i].lvl_q    = s_q.ch[i].raw_q;
            s_d.ch[i].db_cnt_q = DB_RST;
          end else begin
            s_d.ch[i].db_cnt_q = db_next[DB_W-1:0];
          end
        end
      end

      // ****************************************
      // Pull network
      // ****************************************
      s_d.ch[i].pu_q = c.pull_sel[0];   // (R10)
      s_d.ch[i].pd_q = c.pull_sel[1];   // (R10)

      // ****************************************
      // PWM generator
      // ****************************************
      ph_sum = {1'b0, s_q.ch[i].phase_q} + {1'b0, c.pwm_freq_inc};   // (R11)
      s_d.ch[i].phase_q = ph_sum[DUTY_W-1:0];
      wrap = ph_sum[DUTY_W];

      // ****************************************
      // Duty ramp
      // ****************************************
      s_d.ch[i].duty_q = ramp_duty(c.pwm_mode, c.out_level, wrap,
                                   s_q.ch[i].duty_q, c.pwm_duty, c.ramp_step);   // (R12) (R13) (R14) (R15)

      // ****************************************
      // Drive decision
      // ****************************************
      pwm_bit = pwm_level(s_q.ch[i].phase_q, s_q.ch[i].duty_q);   // (R18)
      drive   = drive_level(c.pwm_en, c.pwm_mode, c.out_level, pwm_bit);   // (R14)

      // ****************************************
      // Switch selection
      // ****************************************
      if (c.is_output) begin   // (R1)
        case (c.drive_sel)   // (R16)
          IDPC_DRV_HIGH: begin
            want_h = drive;   // (R6)
            want_l = 1'b0;
          end
          IDPC_DRV_LOW: begin
            want_h = 1'b0;
            want_l = drive;   // (R7)
          end
          default: begin
            want_h = drive;
            want_l = !drive;
          end
        endcase
      end else begin
        want_h = 1'b0;   // (R9)
        want_l = 1'b0;   // (R9)
      end

      // ****************************************
      // Interlock and break-before-make
      // ****************************************
      if ((s_q.ch[i].hs_q && !want_h) || (s_q.ch[i].ls_q && !want_l)) begin
        s_d.ch[i].hs_q = s_q.ch[i].hs_q && want_h;   // (R8)
        s_d.ch[i].ls_q = s_q.ch[i].ls_q && want_l;   // (R8)
        s_d.ch[i].dead_q = (c.drive_sel == IDPC_DRV_PUSH_PULL) ? c.dead_cycles : DEAD_RST;   // (R17) (R19)
      end else if (s_q.ch[i].dead_q != DEAD_RST) begin
        s_d.ch[i].dead_q = s_q.ch[i].dead_q - 8'h01;   // (R17) (R19)
      end else if (s_q.ch[i].hs_q || s_q.ch[i].ls_q) begin
        s_d.ch[i].hs_q = s_q.ch[i].hs_q;
        s_d.ch[i].ls_q = s_q.ch[i].ls_q;
      end else begin
        s_d.ch[i].hs_q = want_h;   // (R6)
        s_d.ch[i].ls_q = want_l && !want_h;   // (R7) (R8)
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign adc_convert = s_q.conv_q;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      din_state[i]    = s_q.ch[i].lvl_q;
      high_side_on[i] = s_q.ch[i].hs_q;
      low_side_on[i]  = s_q.ch[i].ls_q;
      pull_up_on[i]   = s_q.ch[i].pu_q;
      pull_down_on[i] = s_q.ch[i].pd_q;
    end
  end

endmodule : idpc_dio

`default_nettype wire

// >>> hw/idpc_pkg.sv
// Package for the industrial digital I/O channel block: sizes, rates, encodings and carriers.
// Assumes one 20 MHz system clock shared by the whole block.
package idpc_pkg;

  // ****************************************
  // Sizes and rates
  // ****************************************
  localparam int          NUM_CH       = 16;
  localparam int          ADC_W        = 14;
  localparam int          DUTY_W       = 16;
  localparam int          DB_W         = 16;
  localparam int          DEAD_W       = 8;
  localparam int          SYS_CLK_HZ   = 20_000_000;
  localparam int          SAMPLE_HZ    = 200_000;
  localparam int          SAMPLE_DIV   = SYS_CLK_HZ / SAMPLE_HZ;
  localparam int          DIV_W        = 7;
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(SAMPLE_DIV - 1);
  localparam logic [DIV_W-1:0]  DIV_RST   = 7'h00;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 16'hFFFF;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 16'h0000;
  localparam logic [DB_W-1:0]   DB_RST    = 16'h0000;
  localparam logic [DEAD_W-1:0] DEAD_RST  = 8'h00;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    IDPC_PWM_CONT  = 2'b00,
    IDPC_PWM_SOFT_START = 2'b01,
    IDPC_PWM_SOFT_STOP  = 2'b10
  } idpc_pwm_mode_e;

  typedef enum logic [1:0] {
    IDPC_DRV_HIGH = 2'b00,
    IDPC_DRV_LOW  = 2'b01,
    IDPC_DRV_PUSH_PULL = 2'b10
  } idpc_drive_e;

  typedef enum logic [1:0] {
    IDPC_PULL_NONE = 2'b00,
    IDPC_PULL_UP   = 2'b01,
    IDPC_PULL_DOWN = 2'b10,
    IDPC_PULL_MID  = 2'b11
  } idpc_pull_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic                is_output;
    logic                out_level;
    logic [ADC_W-1:0]    thr_high;
    logic [ADC_W-1:0]    thr_low;
    logic                db_en;
    logic [DB_W-1:0]     db_delay;
    idpc_pull_e          pull_sel;
    logic                pwm_en;
    idpc_pwm_mode_e      pwm_mode;
    idpc_drive_e         drive_sel;
    logic [DUTY_W-1:0]   pwm_freq_inc;
    logic [DUTY_W-1:0]   pwm_duty;
    logic [DUTY_W-1:0]   ramp_step;
    logic [DEAD_W-1:0]   dead_cycles;
  } idpc_cfg_s;

  typedef struct packed {
    logic                raw_q;
    logic                lvl_q;
    logic [DB_W-1:0]     db_cnt_q;
    logic [DUTY_W-1:0]   phase_q;
    logic [DUTY_W-1:0]   duty_q;
    logic                hs_q;
    logic                ls_q;
    logic [DEAD_W-1:0]   dead_q;
    logic                pu_q;
    logic                pd_q;
  } idpc_ch_s;

  typedef struct packed {
    logic [DIV_W-1:0]    div_q;
    logic                conv_q;
    idpc_ch_s [NUM_CH-1:0] ch;
  } idpc_state_s;

endpackage : idpc_pkg

// >>> verification/idpc_dio_props.sv
// Port checker of the channel block.
// Assumes channel 0 as input, channel 1 as switched output, channel 3 as pull probe.
`timescale 1ns/1ps
`default_nettype none
module idpc_dio_props
  import idpc_pkg::*;
(
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire idpc_cfg_s [NUM_CH-1:0]       ch_cfg,
  input wire logic [NUM_CH-1:0][ADC_W-1:0] adc_data,
  input wire logic                         adc_convert,
  input wire logic [NUM_CH-1:0]            din_state,
  input wire logic [NUM_CH-1:0]            high_side_on,
  input wire logic [NUM_CH-1:0]            low_side_on,
  input wire logic [NUM_CH-1:0]            pull_up_on,
  input wire logic [NUM_CH-1:0]            pull_down_on
);
  logic [7:0] gap_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    if (rst) gap_q <= 8'hFF;
    else if (low_side_on[1]) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  sequence s_in(c);
    adc_convert && c && !ch_cfg[0].db_en && !ch_cfg[0].is_output;
  endsequence
  sequence s_full;
    ch_cfg[1].is_output && ch_cfg[1].out_level && ch_cfg[1].pwm_en && ch_cfg[1].pwm_duty == DUTY_FULL
      && ch_cfg[1].pwm_mode == IDPC_PWM_CONT && ch_cfg[1].drive_sel == IDPC_DRV_HIGH;
  endsequence
  a_no_overlap: assert property ((high_side_on & low_side_on) == 16'h0000)
    else $error("both switches on");
  a_input_off: assert property (!$past(ch_cfg[1].is_output) |-> !high_side_on[1] && !low_side_on[1])
    else $error("input channel driven");
  a_conv_gap: assert property (adc_convert |=> !adc_convert [*8])
    else $error("convert pulse too long");
  a_conv_rate: assert property (adc_convert |-> ##100 adc_convert)
    else $error("convert rate wrong");
  a_din_high: assert property (s_in(adc_data[0] > ch_cfg[0].thr_high) |-> ##2 din_state[0])
    else $error("high sample not one");
  a_din_low: assert property (s_in(adc_data[0] < ch_cfg[0].thr_low) |-> ##2 !din_state[0])
    else $error("low sample not zero");
  a_pull_map: assert property (!$past(rst) |-> pull_up_on[3] == $past(ch_cfg[3].pull_sel[0])
    && pull_down_on[3] == $past(ch_cfg[3].pull_sel[1])) else $error("pull network wrong");
  a_bbm_gap: assert property (ch_cfg[1].drive_sel == IDPC_DRV_PUSH_PULL && gap_q <= ch_cfg[1].dead_cycles
    |-> !high_side_on[1]) else $error("dead interval short");
  a_full_on: assert property (s_full [*4] |-> high_side_on[1])
    else $error("full duty not on");
endmodule : idpc_dio_props
bind idpc_dio idpc_dio_props u_props (.sys_clk, .rst, .ch_cfg, .adc_data, .adc_convert, .din_state,
  .high_side_on, .low_side_on, .pull_up_on, .pull_down_on);
`default_nettype wire

// >>> verification/idpc_dio_tb.sv
// Self-checking bench of the channel block.
// Assumes the field model feeds the converters; stimulus changes at falling edges.
`timescale 1ns/1ps
`default_nettype none
module idpc_dio_tb
  import idpc_pkg::*;
;
  logic                         sys_clk = 1'b0;
  logic                         rst = 1'b1;
  idpc_cfg_s [NUM_CH-1:0]       cfg = '0;
  logic [NUM_CH-1:0][ADC_W-1:0] ext = '0;
  logic [NUM_CH-1:0][ADC_W-1:0] adc_data;
  logic                         adc_convert;
  logic [NUM_CH-1:0]            din_state, hs, ls, pu, pd;
  int                           num_errors = 0;
  int                           n_tests = 0;
  idpc_dio u_dut (.sys_clk(sys_clk), .rst(rst), .ch_cfg(cfg), .adc_data(adc_data), .adc_convert(adc_convert),
    .din_state(din_state), .high_side_on(hs), .low_side_on(ls), .pull_up_on(pu), .pull_down_on(pd));
  idpc_field u_field (.high_side_on(hs), .low_side_on(ls), .ext_code(ext), .adc_data(adc_data));
  task automatic chk(string what, int unsigned exp, logic [31:0] got);
    n_tests++;
    if (got !== 32'(exp)) begin
      num_errors++;
      $display("unexpected %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic sample(logic [ADC_W-1:0] code);
    ext[0] = code;
    for (int k = 0; k < 200 && adc_convert !== 1'b1; k++) tick(1);
    tick(3);
  endtask : sample
  task automatic count_hs(int n, output int c);
    c = 0;
    repeat (n) begin
      tick(1);
      c += int'(hs[1] === 1'b1);
    end
  endtask : count_hs
  task automatic t_input;
    logic [ADC_W-1:0] code [6] = '{14'h2000, 14'h0C00, 14'h0100, 14'h0C00, 14'h1000, 14'h1001};
    bit               exp [6] = '{1, 1, 0, 0, 0, 1};
    cfg[0].thr_high = 14'h1000;
    cfg[0].thr_low = 14'h0800;
    foreach (code[i]) begin
      sample(code[i]);
      chk("din_state", exp[i], din_state[0]);
    end
    cfg[0].db_en = 1'b1;
    cfg[0].db_delay = 16'h0003;
    sample(14'h0100);
    chk("din_debounce", 1, din_state[0]);
    repeat (3) sample(14'h0100);
    chk("din_debounce", 0, din_state[0]);
    sample(14'h2000);
    chk("din_glitch", 0, din_state[0]);
    repeat (4) sample(14'h0100);
    chk("din_glitch", 0, din_state[0]);
    cfg[0].db_en = 1'b0;
    $display("input path done");
  endtask : t_input
  task automatic t_switch;
    int c;
    for (int p = 0; p < 4; p++) begin
      cfg[3].pull_sel = idpc_pull_e'(p);
      tick(2);
      chk("pull_up", p & 1, pu[3]);
      chk("pull_down", p >> 1, pd[3]);
    end
    cfg[1].is_output = 1'b1;
    cfg[1].drive_sel = IDPC_DRV_PUSH_PULL;
    cfg[1].dead_cycles = 8'h03;
    tick(3);
    chk("low_side", 1, ls[1]);
    for (int l = 1; l >= 0; l--) begin
      cfg[1].out_level = l[0];
      c = 0;
      while (c < 20 && (l ? hs[1] : ls[1]) !== 1'b1) begin
        tick(1);
        c++;
      end
      chk("bbm_delay", 5, c);
    end
    cfg[1].out_level = 1'b1;
    cfg[1].drive_sel = IDPC_DRV_HIGH;
    tick(3);
    chk("high_side", 1, hs[1]);
    cfg[1].drive_sel = IDPC_DRV_LOW;
    tick(3);
    chk("low_only", 1, ls[1]);
    cfg[1].is_output = 1'b0;
    tick(2);
    chk("off_state", 0, {hs[1], ls[1]});
    $display("switching done");
  endtask : t_switch
  task automatic t_pwm;
    logic [DUTY_W-1:0] duty [4] = '{16'h0000, 16'h4000, 16'hC000, 16'hFFFF};
    int                c;
    cfg[1].is_output = 1'b1;
    cfg[1].drive_sel = IDPC_DRV_HIGH;
    cfg[1].pwm_en = 1'b1;
    cfg[1].pwm_freq_inc = 16'h1000;
    foreach (duty[i]) begin
      cfg[1].pwm_duty = duty[i];
      tick(32);
      count_hs(64, c);
      chk("pwm_high", 4 * (duty[i] >> 12) + (duty[i] == DUTY_FULL ? 4 : 0), c);
    end
    cfg[1].pwm_duty = 16'hC000;
    cfg[1].ramp_step = 16'h4000;
    cfg[1].pwm_mode = IDPC_PWM_SOFT_START;
    cfg[1].out_level = 1'b0;
    tick(32);
    cfg[1].out_level = 1'b1;
    count_hs(16, c);
    chk("ramp_up_first", 1, c < 9);
    tick(48);
    count_hs(64, c);
    chk("ramp_up_end", 48, c);
    cfg[1].pwm_mode = IDPC_PWM_SOFT_STOP;
    tick(32);
    cfg[1].out_level = 1'b0;
    count_hs(16, c);
    chk("ramp_down_first", 1, c > 0);
    tick(48);
    count_hs(64, c);
    chk("ramp_down_end", 0, c);
    $display("pwm done");
  endtask : t_pwm
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (10000) @(posedge sys_clk);
    num_errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk("reset_outputs", 0, |{adc_convert, din_state, hs, ls, pu, pd});
    t_input();
    t_switch();
    t_pwm();
    results();
  end
endmodule : idpc_dio_tb
`default_nettype wire

// >>> verification/idpc_field.sv
// Field wiring model: pins, loads and sensors seen by the channel converters.
// Assumes the bench sets the external level code of every undriven pin.
`timescale 1ns/1ps
`default_nettype none
module idpc_field
  import idpc_pkg::*;
(
  input  wire logic [NUM_CH-1:0]            high_side_on,
  input  wire logic [NUM_CH-1:0]            low_side_on,
  input  wire logic [NUM_CH-1:0][ADC_W-1:0] ext_code,
  output logic      [NUM_CH-1:0][ADC_W-1:0] adc_data
);
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      adc_data[i] = ext_code[i];
      if (high_side_on[i]) adc_data[i] = 14'h3FFF;
      if (low_side_on[i]) adc_data[i] = 14'h0000;
    end
  end
endmodule : idpc_field
`default_nettype wire
